// ---- core/bcsr_regs.svh ----
`ifndef BCSR_REGS_SVH
`define BCSR_REGS_SVH

// Port addresses
`define BCSR_ADDR_END_LOW 4'h2
`define BCSR_ADDR_CTRL    4'h3
`define BCSR_ADDR_STAT    4'h4
`define BCSR_ADDR_TAP_LO  4'h5
`define BCSR_ADDR_TAP_HI  4'h8
`define BCSR_ADDR_CNT_LO  4'hA
`define BCSR_ADDR_CNT_HI  4'hF

// Control byte fields
`define BCSR_CTRL_TEST_HI 7
`define BCSR_CTRL_TEST_LO 6
`define BCSR_CTRL_TX_CLOCK_OUT_POLARITY 5
`define BCSR_CTRL_DIR     4
`define BCSR_CTRL_RAM     3
`define BCSR_CTRL_COUNT   2
`define BCSR_CTRL_SEED    1
`define BCSR_CTRL_PL8     0

// Status byte fields
`define BCSR_STAT_SPARE   7
`define BCSR_STAT_RA1     6
`define BCSR_STAT_RA0     5
`define BCSR_STAT_BED     4
`define BCSR_STAT_ERROR_COUNTER_OVERFLOW   3
`define BCSR_STAT_BIT_COUNTER_OVERFLOW    2
`define BCSR_STAT_RECEIVE_LOCK_LOST    1
`define BCSR_STAT_SYNC    0

// Reset values
`define BCSR_CTRL_RST     8'h00
`define BCSR_END_LOW_RST  8'h00
`define BCSR_STAT_RST     8'h00
`define BCSR_RDATA_RST    8'h00

// Run detection, 40 bits
`define BCSR_RUN_W        6
`define BCSR_RUN_LEN      6'h28
`define BCSR_RUN_ZERO     6'h00
`define BCSR_RUN_ONE      6'h01

`endif

// ---- core/bcsr_pkg.sv ----
package bcsr_pkg;

  typedef logic [7:0] bcsr_byte_t;

  typedef enum logic {
    BCSR_OWNER_ENGINE = 1'b0,
    BCSR_OWNER_HOST   = 1'b1
  } bcsr_ram_owner_t;

  typedef enum logic {
    BCSR_DIR_WRITE = 1'b0,
    BCSR_DIR_READ  = 1'b1
  } bcsr_ram_dir_t;

endpackage

// ---- core/bcsr_run_detect.sv ----
`timescale 1ns/10ps
`include "bcsr_regs.svh"
module bcsr_run_detect
  import bcsr_pkg::*;
(
  input  logic i_clk,
  input  logic i_rst,
  input  logic i_enable,
  input  logic i_bit_valid,
  input  logic i_bit,
  input  logic i_match,
  output logic o_run
);

  logic [`BCSR_RUN_W-1:0] cnt_reg;
  logic [`BCSR_RUN_W-1:0] cnt_next;
  logic                   run_reg;
  logic                   run_next;

  // Saturating run length
  always_comb begin
    cnt_next = cnt_reg;
    if (!i_enable) begin
      cnt_next = `BCSR_RUN_ZERO;
    end else if (i_bit_valid) begin
      if (i_bit != i_match) begin
        cnt_next = `BCSR_RUN_ZERO;
      end else if (cnt_reg != `BCSR_RUN_LEN) begin
        cnt_next = cnt_reg + `BCSR_RUN_ONE;
      end
    end
    run_next = (cnt_next == `BCSR_RUN_LEN);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg <= `BCSR_RUN_ZERO;
      run_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
    end
  end

  assign o_run = run_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  AST_RUN_SET:
    assert property (i_enable && i_bit_valid && i_bit == i_match && cnt_reg == `BCSR_RUN_LEN - `BCSR_RUN_ONE
                     |=> o_run)
    else $error("Run flag missing after 40 matching bits");
  AST_RUN_BREAK:
    assert property (i_bit_valid && i_bit != i_match |=> !o_run)
    else $error("Run flag kept after a breaking bit");

endmodule // bcsr_run_detect

// ---- core/bcsr_top.sv ----
`timescale 1ns/10ps
`include "bcsr_regs.svh"
module bcsr_top
  import bcsr_pkg::*;
(
  input  logic       I_CLK_SYS,
  input  logic       I_SYS_RST,
  input  logic [3:0] I_ADDR,
  input  logic [7:0] I_WDATA,
  input  logic       I_WR,
  input  logic       I_RD,
  input  logic       I_TX_CLK_RAW,
  input  logic       I_PRBS_MODE,
  input  logic       I_RX_BIT_VALID,
  input  logic       I_RX_BIT,
  input  logic       I_BIT_ERR_PULSE,
  input  logic       I_ERR_CNT_OVF,
  input  logic       I_BIT_CNT_OVF,
  input  logic       I_SYNC_LOCKED,
  output logic [7:0] O_RDATA,
  output logic       O_RDATA_VALID,
  output logic       O_TX_CLK_OUT,
  output logic       O_RAM_HOST_OWN,
  output logic       O_RAM_HOST_WR_EN,
  output logic       O_RAM_HOST_RD_EN,
  output logic [8:0] O_PATTERN_END_ADDR,
  output logic       O_BIT_CNT_SEL,
  output logic       O_ERR_CNT_SEL,
  output logic       O_TAP_SEL,
  output logic       O_SEED_SEL,
  output logic [2:0] O_BANK_INDEX,
  output logic       O_BANK_WRITE
);

  bcsr_byte_t      end_low_reg;
  bcsr_byte_t      end_low_next;
  bcsr_byte_t      ctrl_reg;
  bcsr_byte_t      ctrl_next;
  bcsr_byte_t      flag_reg;
  bcsr_byte_t      flag_next;
  bcsr_byte_t      rdata_reg;
  bcsr_byte_t      rdata_next;
  logic            rvalid_reg;
  logic            rvalid_next;
  logic            txclk_reg;
  logic            txclk_next;
  logic            host_wr_reg;
  logic            host_wr_next;
  logic            host_rd_reg;
  logic            host_rd_next;
  logic [8:0]      end_addr_reg;
  logic [8:0]      end_addr_next;
  logic            bit_sel_reg;
  logic            bit_sel_next;
  logic            err_sel_reg;
  logic            err_sel_next;
  logic            tap_sel_reg;
  logic            tap_sel_next;
  logic            seed_sel_reg;
  logic            seed_sel_next;
  logic [2:0]      index_reg;
  logic [2:0]      index_next;
  logic            bank_wr_reg;
  logic            bank_wr_next;
  logic            stat_rd;
  logic            access;
  logic            in_cnt;
  logic            in_tap;
  logic [1:0]      run_hit;
  logic            last_rd_stat;
  bcsr_ram_owner_t owner;
  bcsr_ram_dir_t   dir;

  function automatic logic bcsr_in_range(input logic [3:0] a,
                                         input logic [3:0] lo,
                                         input logic [3:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  assign stat_rd = I_RD && (I_ADDR == `BCSR_ADDR_STAT);
  assign access  = I_RD || I_WR;
  assign in_cnt  = bcsr_in_range(I_ADDR, `BCSR_ADDR_CNT_LO, `BCSR_ADDR_CNT_HI);
  assign in_tap  = bcsr_in_range(I_ADDR, `BCSR_ADDR_TAP_LO, `BCSR_ADDR_TAP_HI);
  assign owner   = bcsr_ram_owner_t'(ctrl_next[`BCSR_CTRL_RAM]);
  assign dir     = bcsr_ram_dir_t'(ctrl_next[`BCSR_CTRL_DIR]);

  // Run detectors: index 1 ones, index 0 zeros
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_run
      bcsr_run_detect u_run (
        .i_clk       (I_CLK_SYS),
        .i_rst       (I_SYS_RST),
        .i_enable    (I_PRBS_MODE),
        .i_bit_valid (I_RX_BIT_VALID),
        .i_bit       (I_RX_BIT),
        .i_match     (1'(g)),
        .o_run       (run_hit[g])
      );
    end
  endgenerate

  // Writable bytes; test bits stored as written
  always_comb begin
    end_low_next = end_low_reg;
    ctrl_next    = ctrl_reg;
    if (I_WR && I_ADDR == `BCSR_ADDR_END_LOW) begin
      end_low_next = I_WDATA;
    end
    if (I_WR && I_ADDR == `BCSR_ADDR_CTRL) begin
      ctrl_next = I_WDATA;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      end_low_reg <= `BCSR_END_LOW_RST;
      ctrl_reg    <= `BCSR_CTRL_RST;
    end else begin
      end_low_reg <= end_low_next;
      ctrl_reg    <= ctrl_next;
    end
  end

  // Latched flags; OR with the event keeps a set alive over a read
  // held until read, set wins
  always_comb begin
    flag_next = `BCSR_STAT_RST;
    flag_next[`BCSR_STAT_BED]   = I_BIT_ERR_PULSE | (flag_reg[`BCSR_STAT_BED] & ~stat_rd);
    flag_next[`BCSR_STAT_ERROR_COUNTER_OVERFLOW] = I_ERR_CNT_OVF | (flag_reg[`BCSR_STAT_ERROR_COUNTER_OVERFLOW] & ~stat_rd);
    flag_next[`BCSR_STAT_BIT_COUNTER_OVERFLOW]  = I_BIT_CNT_OVF | (flag_reg[`BCSR_STAT_BIT_COUNTER_OVERFLOW] & ~stat_rd);
    flag_next[`BCSR_STAT_RA1]   = run_hit[1] | (flag_reg[`BCSR_STAT_RA1] & ~stat_rd);
    flag_next[`BCSR_STAT_RA0]   = run_hit[0] | (flag_reg[`BCSR_STAT_RA0] & ~stat_rd);
    flag_next[`BCSR_STAT_RECEIVE_LOCK_LOST]  = ~I_SYNC_LOCKED | (flag_reg[`BCSR_STAT_RECEIVE_LOCK_LOST] & ~stat_rd);
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      flag_reg <= `BCSR_STAT_RST;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Read port; status captured before its clear
  always_comb begin
    rdata_next  = `BCSR_RDATA_RST;
    rvalid_next = 1'b0;
    if (I_RD) begin
      case (I_ADDR)
        `BCSR_ADDR_END_LOW: begin
          rdata_next  = end_low_reg;
          rvalid_next = 1'b1;
        end
        `BCSR_ADDR_CTRL: begin
          rdata_next  = ctrl_reg;
          rvalid_next = 1'b1;
        end
        `BCSR_ADDR_STAT: begin
          rdata_next = flag_reg;
          rdata_next[`BCSR_STAT_SYNC]  = I_SYNC_LOCKED;
          rdata_next[`BCSR_STAT_SPARE] = 1'b0;
          rvalid_next = 1'b1;
        end
        default: begin
          rvalid_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      rdata_reg  <= `BCSR_RDATA_RST;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Controls steering the rest of the tester
  always_comb begin
    txclk_next    = I_TX_CLK_RAW ^ ctrl_reg[`BCSR_CTRL_TX_CLOCK_OUT_POLARITY];
    host_wr_next  = (owner == BCSR_OWNER_HOST) && (dir == BCSR_DIR_WRITE);
    host_rd_next  = (owner == BCSR_OWNER_HOST) && (dir == BCSR_DIR_READ);
    end_addr_next = {ctrl_next[`BCSR_CTRL_PL8], end_low_next};
    bit_sel_next  = access && in_cnt && !ctrl_reg[`BCSR_CTRL_COUNT];
    err_sel_next  = access && in_cnt && ctrl_reg[`BCSR_CTRL_COUNT];
    tap_sel_next  = access && in_tap && !ctrl_reg[`BCSR_CTRL_SEED];
    seed_sel_next = access && in_tap && ctrl_reg[`BCSR_CTRL_SEED];
    index_next    = 3'h0;
    if (in_cnt) begin
      index_next = 3'(I_ADDR - `BCSR_ADDR_CNT_LO);
    end else if (in_tap) begin
      index_next = 3'(I_ADDR - `BCSR_ADDR_TAP_LO);
    end
    bank_wr_next  = I_WR && (in_cnt || in_tap);
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      txclk_reg    <= 1'b0;
      host_wr_reg  <= 1'b0;
      host_rd_reg  <= 1'b0;
      end_addr_reg <= 9'h000;
      bit_sel_reg  <= 1'b0;
      err_sel_reg  <= 1'b0;
      tap_sel_reg  <= 1'b0;
      seed_sel_reg <= 1'b0;
      index_reg    <= 3'h0;
      bank_wr_reg  <= 1'b0;
      last_rd_stat <= 1'b0;
    end else begin
      txclk_reg    <= txclk_next;
      host_wr_reg  <= host_wr_next;
      host_rd_reg  <= host_rd_next;
      end_addr_reg <= end_addr_next;
      bit_sel_reg  <= bit_sel_next;
      err_sel_reg  <= err_sel_next;
      tap_sel_reg  <= tap_sel_next;
      seed_sel_reg <= seed_sel_next;
      index_reg    <= index_next;
      bank_wr_reg  <= bank_wr_next;
      last_rd_stat <= stat_rd;
    end
  end

  assign O_RDATA            = rdata_reg;
  assign O_RDATA_VALID      = rvalid_reg;
  assign O_TX_CLK_OUT       = txclk_reg;
  assign O_RAM_HOST_OWN     = ctrl_reg[`BCSR_CTRL_RAM];
  assign O_RAM_HOST_WR_EN   = host_wr_reg;
  assign O_RAM_HOST_RD_EN   = host_rd_reg;
  assign O_PATTERN_END_ADDR = end_addr_reg;
  assign O_BIT_CNT_SEL      = bit_sel_reg;
  assign O_ERR_CNT_SEL      = err_sel_reg;
  assign O_TAP_SEL          = tap_sel_reg;
  assign O_SEED_SEL         = seed_sel_reg;
  assign O_BANK_INDEX       = index_reg;
  assign O_BANK_WRITE       = bank_wr_reg;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);

  AST_TX_POLARITY:
    assert property (##1 O_TX_CLK_OUT == ($past(I_TX_CLK_RAW) ^ $past(ctrl_reg[`BCSR_CTRL_TX_CLOCK_OUT_POLARITY])))
    else $error("Transmit clock polarity wrong");
  AST_HOST_DIR:
    assert property (O_RAM_HOST_OWN |-> (O_RAM_HOST_RD_EN == ctrl_reg[`BCSR_CTRL_DIR])
                     && (O_RAM_HOST_WR_EN == !ctrl_reg[`BCSR_CTRL_DIR]))
    else $error("RAM direction wrong");
  AST_ENGINE_OWN:
    assert property (!O_RAM_HOST_OWN |-> !O_RAM_HOST_WR_EN && !O_RAM_HOST_RD_EN)
    else $error("Host access while engine owns RAM");
  AST_CNT_BANK:
    assert property (I_RD && in_cnt |=> (O_ERR_CNT_SEL == $past(ctrl_reg[`BCSR_CTRL_COUNT]))
                     && (O_BIT_CNT_SEL != O_ERR_CNT_SEL))
    else $error("Counter bank select wrong");
  AST_TAP_BANK:
    assert property (access && in_tap |=> (O_SEED_SEL == $past(ctrl_reg[`BCSR_CTRL_SEED]))
                     && (O_TAP_SEL != O_SEED_SEL) && O_BANK_INDEX == $past(3'(I_ADDR - `BCSR_ADDR_TAP_LO)))
    else $error("Tap bank select wrong");
  AST_END_ADDR:
    assert property (O_PATTERN_END_ADDR == {ctrl_reg[`BCSR_CTRL_PL8], end_low_reg})
    else $error("End address mismatch");
  AST_FLAG_HOLD:
    assert property (flag_reg[`BCSR_STAT_BIT_COUNTER_OVERFLOW] && !stat_rd |=> flag_reg[`BCSR_STAT_BIT_COUNTER_OVERFLOW])
    else $error("Latched flag dropped without read");
  AST_BED_CLEAR:
    assert property (stat_rd && !I_BIT_ERR_PULSE |=> !flag_reg[`BCSR_STAT_BED])
    else $error("Error flag not cleared by read");
  AST_SET_WINS:
    assert property (stat_rd && I_ERR_CNT_OVF |=> flag_reg[`BCSR_STAT_ERROR_COUNTER_OVERFLOW])
    else $error("Overflow lost on clearing read");
  AST_RECEIVE_LOCK_LOST_HUNT:
    assert property (!I_SYNC_LOCKED |=> flag_reg[`BCSR_STAT_RECEIVE_LOCK_LOST] [*1] ##1 1)
    else $error("Sync loss flag not set while hunting");
  AST_RUN_PERSIST:
    assert property (stat_rd && run_hit[1] |=> flag_reg[`BCSR_STAT_RA1])
    else $error("All-ones flag cleared while run lasts");
  AST_SYNC_LIVE:
    assert property (last_rd_stat |-> O_RDATA_VALID && O_RDATA[`BCSR_STAT_SYNC] == $past(I_SYNC_LOCKED)
                     && !O_RDATA[`BCSR_STAT_SPARE])
    else $error("Status sync bit not live");
  AST_RECEIVE_LOCK_LOST_HELD:
    assert property (flag_reg[`BCSR_STAT_RECEIVE_LOCK_LOST] && !stat_rd |=> flag_reg[`BCSR_STAT_RECEIVE_LOCK_LOST])
    else $error("Sync loss flag dropped before a read");
  AST_BIT_COUNTER_OVERFLOW_SET:
    assert property (I_BIT_CNT_OVF |=> flag_reg[`BCSR_STAT_BIT_COUNTER_OVERFLOW])
    else $error("Bit counter overflow not flagged");
  AST_BIT_COUNTER_OVERFLOW_CLEAR:
    assert property (stat_rd && !I_BIT_CNT_OVF |=> !flag_reg[`BCSR_STAT_BIT_COUNTER_OVERFLOW])
    else $error("Bit counter overflow not cleared by read");
  AST_BED_SET:
    assert property (I_BIT_ERR_PULSE |=> flag_reg[`BCSR_STAT_BED])
    else $error("Bit error not flagged");
  AST_RA1_CLEAR:
    assert property (stat_rd && !run_hit[1] |=> !flag_reg[`BCSR_STAT_RA1])
    else $error("All-ones flag kept after run ended and read");
  AST_RA0_PERSIST:
    assert property (stat_rd && run_hit[0] |=> flag_reg[`BCSR_STAT_RA0])
    else $error("All-zeros flag cleared while run lasts");
  AST_RA0_CLEAR:
    assert property (stat_rd && !run_hit[0] |=> !flag_reg[`BCSR_STAT_RA0])
    else $error("All-zeros flag kept after run ended and read");
  AST_BANK_WRITE:
    assert property (I_WR && (in_cnt || in_tap) |=> O_BANK_WRITE)
    else $error("Bank write strobe missing");

endmodule // bcsr_top

// ---- sim/bcsr_host_model.sv ----
`timescale 1ns/10ps
module bcsr_host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rdata_valid,
  output logic      [3:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd
);
  initial begin
    o_addr  = 4'h0;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // Called just after a rising edge; returns one idle edge after the taking edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] dv;
    dv = d;
    if (a == 4'h3) dv[7:6] = 2'b00;
    o_addr  = a;
    o_wdata = dv;
    o_wr    = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr    = 1'b0;
    // Released lines show the inverse, never the stale value
    o_addr  = ~a;
    o_wdata = ~dv;
    // Idle edge so back-to-back calls never retoggle the strobe
    @(posedge i_clk);
    #1;
  endtask

  // Answer stands one cycle, taken at the edge after the read edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic v);
    o_addr = a;
    o_rd   = 1'b1;
    @(posedge i_clk);
    #1;
    o_rd   = 1'b0;
    o_addr = ~a;
    @(posedge i_clk);
    d      = i_rdata;
    v      = i_rdata_valid;
    #1;
  endtask
endmodule // bcsr_host_model

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr, rd;
  logic       tx_raw = 1'b0, prbs = 1'b0, bit_vld = 1'b0, rx_bit = 1'b0;
  logic       err_p = 1'b0, ecnt_ovf = 1'b0, bcnt_ovf = 1'b0, locked = 1'b1;
  logic [7:0] rdata;
  logic       rdata_vld, tx_out, ram_own, ram_wr, ram_rd;
  logic [8:0] end_addr;
  logic       bcnt_sel, ecnt_sel, tap_sel, seed_sel, bank_wr;
  logic [2:0] bank_idx;
  logic [8:0] bank_seen;
  int         n_errors = 0;
  int         check_count = 0;

  always #12.5 clk = ~clk;

  // Bank pulses last one cycle; keep them for the checks
  always @(posedge clk) begin
    bank_seen <= {1'b0, bcnt_sel, ecnt_sel, tap_sel, seed_sel, bank_idx, bank_wr};
  end

  bcsr_top u_bcsr_top (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .I_TX_CLK_RAW(tx_raw), .I_PRBS_MODE(prbs), .I_RX_BIT_VALID(bit_vld), .I_RX_BIT(rx_bit),
    .I_BIT_ERR_PULSE(err_p), .I_ERR_CNT_OVF(ecnt_ovf), .I_BIT_CNT_OVF(bcnt_ovf), .I_SYNC_LOCKED(locked),
    .O_RDATA(rdata), .O_RDATA_VALID(rdata_vld), .O_TX_CLK_OUT(tx_out), .O_RAM_HOST_OWN(ram_own),
    .O_RAM_HOST_WR_EN(ram_wr), .O_RAM_HOST_RD_EN(ram_rd), .O_PATTERN_END_ADDR(end_addr),
    .O_BIT_CNT_SEL(bcnt_sel), .O_ERR_CNT_SEL(ecnt_sel), .O_TAP_SEL(tap_sel), .O_SEED_SEL(seed_sel),
    .O_BANK_INDEX(bank_idx), .O_BANK_WRITE(bank_wr));

  bcsr_host_model u_bcsr_host_model (.i_clk(clk), .i_rdata(rdata), .i_rdata_valid(rdata_vld),
    .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    u_bcsr_host_model.rd(a, d, v);
    check({v, d}, {1'b1, e});
  endtask

  task automatic bits(input logic b, input int n);
    repeat (n) begin
      bit_vld = 1'b1;
      rx_bit  = b;
      cyc(1);
    end
    bit_vld = 1'b0;
    rx_bit  = ~b;
  endtask

  task automatic t_reset;
    logic [7:0] d;
    logic       v;
    check(end_addr, 9'h000);
    check({6'h00, ram_own, ram_wr, ram_rd}, 9'h000);
    rchk(4'h3, 8'h00);
    rchk(4'h4, 8'h01);
    u_bcsr_host_model.rd(4'h0, d, v);
    check({v, d}, 9'h000);
    u_bcsr_host_model.wr(4'h4, 8'hFF);
    rchk(4'h4, 8'h01);
    $display("test reset done");
  endtask

  task automatic t_ctrl;
    u_bcsr_host_model.wr(4'h2, 8'hA5);
    u_bcsr_host_model.wr(4'h3, 8'h08);
    check({6'h00, ram_own, ram_wr, ram_rd}, 9'h006);
    u_bcsr_host_model.wr(4'h3, 8'h18);
    check({6'h00, ram_own, ram_wr, ram_rd}, 9'h005);
    u_bcsr_host_model.wr(4'h3, 8'hC1);
    check({6'h00, ram_own, ram_wr, ram_rd}, 9'h000);
    check(end_addr, 9'h1A5);
    rchk(4'h3, 8'h01);
    rchk(4'h2, 8'hA5);
    $display("test control done");
  endtask

  task automatic t_txclk;
    for (int p = 0; p < 2; p++) begin
      u_bcsr_host_model.wr(4'h3, p[0] ? 8'h20 : 8'h00);
      for (int r = 0; r < 2; r++) begin
        tx_raw = r[0];
        cyc(1);
        check({8'h00, tx_out}, {8'h00, r[0] ^ p[0]});
      end
    end
    $display("test tx clock done");
  endtask

  task automatic t_banks;
    logic [7:0] d;
    logic       v;
    logic       hi, lo;
    for (int s = 0; s < 2; s++) begin
      u_bcsr_host_model.wr(4'h3, {5'h00, s[0], s[0], 1'b0});
      for (int a = 5; a < 16; a++) begin
        u_bcsr_host_model.wr(a[3:0], 8'h5A);
        hi = (a >= 10);
        lo = (a <= 8);
        check(bank_seen,
              {1'b0, hi & ~s[0], hi & s[0], lo & ~s[0], lo & s[0],
               hi ? 3'(a - 10) : (lo ? 3'(a - 5) : 3'h0), hi | lo});
      end
    end
    u_bcsr_host_model.rd(4'hB, d, v);
    check(bank_seen, 9'h042);
    check({v, d}, 9'h000);
    $display("test banks done");
  endtask

  task automatic t_flags;
    logic [7:0] d;
    logic       v;
    err_p    = 1'b1;
    ecnt_ovf = 1'b1;
    bcnt_ovf = 1'b1;
    cyc(1);
    {err_p, ecnt_ovf, bcnt_ovf} = 3'b000;
    cyc(2);
    rchk(4'h4, 8'h1D);
    rchk(4'h4, 8'h01);
    err_p = 1'b1;
    // Event only in the clearing cycle
    fork
      u_bcsr_host_model.rd(4'h4, d, v);
      begin
        cyc(1);
        err_p = 1'b0;
      end
    join
    check({v, d}, 9'h101);
    rchk(4'h4, 8'h11);
    rchk(4'h4, 8'h01);
    locked = 1'b0;
    cyc(2);
    rchk(4'h4, 8'h02);
    rchk(4'h4, 8'h02);
    locked = 1'b1;
    cyc(1);
    rchk(4'h4, 8'h03);
    rchk(4'h4, 8'h01);
    $display("test flags done");
  endtask

  task automatic t_runs;
    bits(1'b1, 40);
    cyc(3);
    rchk(4'h4, 8'h01);
    prbs = 1'b1;
    bits(1'b1, 39);
    cyc(3);
    rchk(4'h4, 8'h01);
    bits(1'b1, 1);
    cyc(3);
    rchk(4'h4, 8'h41);
    rchk(4'h4, 8'h41);
    bits(1'b0, 1);
    cyc(3);
    rchk(4'h4, 8'h41);
    rchk(4'h4, 8'h01);
    bits(1'b0, 39);
    cyc(3);
    rchk(4'h4, 8'h21);
    rchk(4'h4, 8'h21);
    bits(1'b1, 1);
    cyc(3);
    rchk(4'h4, 8'h21);
    rchk(4'h4, 8'h01);
    $display("test runs done");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_ctrl();
    t_txclk();
    t_banks();
    t_flags();
    t_runs();
    end_of_test();
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    $display("timeout after 5000 cycles");
    end_of_test();
  end
endmodule // tb_top
